// file: hdl/wsb_pkg.sv
// Constants, field layouts and carrier types for the slot and burst sync block.
// Assumes a single 40 MHz core clock and channel time counted in 1 us ticks.
package wsb_pkg;

    // Clock and timing.
    localparam int CLK_NS = 25;
    localparam int CT_UNIT_NS = 1000;
    localparam int CT_UNIT_CYC = (CT_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int STREAM_IPG_NS = 1000;
    localparam int STREAM_IPG_CYC = (STREAM_IPG_NS + CLK_NS - 1) / CLK_NS;

    // Rates at or below this figure allow standard preambles only.
    localparam logic [9:0] RATE_STD_ONLY_MBPS = 10'h0C8;

    // Field values that mark the end-of-list allocation block.
    localparam logic [3:0] EOL_EP = 4'h0;
    localparam logic EOL_DIR = 1'b0;
    localparam logic EOL_SETUP = 1'b0;
    localparam logic [1:0] EOL_TYPE = 2'h0;
    localparam logic [7:0] BCAST_ID = 8'hFF;

    // Register offsets on the plain register port.
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_GUARD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PCLK = 8'h0C;
    localparam logic [7:0] REG_SLOT = 8'h10;

    // Field positions and reset values.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ID_LSB = 8;
    localparam int CTRL_RATE_LSB = 16;
    localparam int STAT_OK_BIT = 0;
    localparam int STAT_DIR_BIT = 1;
    localparam int STAT_TXW_BIT = 2;
    localparam int STAT_RXW_BIT = 3;
    localparam int STAT_TXB_LSB = 8;
    localparam int STAT_RXB_LSB = 16;
    localparam int SLOT_END_LSB = 16;
    localparam logic [15:0] GUARD_RST = 16'h0002;

    // One channel-time allocation block as the MMC parser hands it over.
    typedef struct packed {
        logic [3:0] ep;
        logic dir_in;
        logic setup;
        logic [1:0] btype;
        logic [7:0] dev_id;
        logic [15:0] start;
        logic [7:0] policy;
    } wsb_cta_t;

    // Register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } wsb_bus_req_t;

    typedef enum logic [1:0] {TX_IDLE, TX_BUSY, TX_IPG} wsb_tx_st_t;
    typedef enum logic [1:0] {MODE_NONE, MODE_DATA, MODE_HS} wsb_mode_t;

endpackage

// file: hdl/wsb_slot_burst.sv
// Device-side slot timing and sliding-window burst sequencing for one endpoint.
// Assumes an MMC parser that strobes preamble start and allocation blocks in order.
//
// Overview of operation
// RULE1: First data packet of a burst always goes out with a standard preamble.
// RULE2: Consecutive data packets in a burst are spaced by the streaming gap.
// RULE3: At 200 Mb/s or below every burst packet uses a standard preamble.
// RULE4: Above 200 Mb/s the block follows the preamble policy pattern of its allocation.
// RULE5: The protocol clock restarts at zero on each MMC preamble start.
// RULE6: Host gives nextMMC and slot starts relative to the current MMC preamble.
// RULE7: Transmission starts exactly when the local clock reaches the slot start.
// RULE8: Receiver opens at least one guard time before the slot start.
// RULE9: Radio may idle between the MMC and the block's own slots.
// RULE10: No transmission before the local clock reaches the IN slot start.
// RULE11: Receiver may close at the next slot start unless that slot is ours.
// RULE12: Slot end comes from the start field of the following block.
// RULE13: The end-of-list block never counts as a real allocation.
// RULE14: End-of-list block has zero endpoint, direction, setup, type and broadcast ID.
// RULE15: Host places nextMMC enough after the end-of-list start, handling rollover.
// RULE16: One data phase carries data packets or one handshake, never both.
// RULE17: Sequence numbers go to data segments in strictly ascending order.
// RULE18: Received data leaves strictly in ascending sequence order.
// RULE19: Retries resend only unacknowledged packets with their original numbers.
// RULE20: The receiver returns its burst acknowledgement in every handshake phase.
// RULE21: At least max packet size times max burst of receive buffering.
// RULE22: Sequence numbers run from zero to max sequence minus one, then wrap.
// RULE23: Burst acknowledgement is a bit vector of the receive window.
// RULE24: A configuration event resets sequences and both windows to full burst.
// RULE25: Packets with sequence numbers outside the receive window are dropped.
// RULE26: Neither window ever spans more than the maximum burst size.
// RULE27: Protocol clock free-runs between MMCs and gates transmitter and receiver.
`timescale 1ns/10ps
`default_nettype none

module wsb_slot_burst
    import wsb_pkg::*;
#(
    parameter int MAX_BURST = 4,
    parameter int MAX_SEQ = 10,
    parameter int MAX_PKT_BYTES = 4
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire wsb_bus_req_t bus_i,
    output logic [31:0] bus_rdata_o,
    input wire logic mmc_pre_i,
    input wire logic cta_valid_i,
    input wire wsb_cta_t cta_i,
    input wire logic cfg_evt_i,
    input wire logic tx_req_i,
    input wire logic tx_hs_i,
    input wire logic tx_done_i,
    output logic tx_go_o,
    output logic [$clog2(MAX_SEQ)-1:0] tx_seq_o,
    output logic tx_std_pre_o,
    output logic tx_hs_o,
    input wire logic ack_in_valid_i,
    input wire logic [MAX_SEQ-1:0] ack_in_i,
    input wire logic rx_pkt_valid_i,
    input wire logic [$clog2(MAX_SEQ)-1:0] rx_seq_i,
    input wire logic [8*MAX_PKT_BYTES-1:0] rx_data_i,
    output logic del_valid_o,
    output logic [$clog2(MAX_SEQ)-1:0] del_seq_o,
    output logic [8*MAX_PKT_BYTES-1:0] del_data_o,
    input wire logic hs_phase_i,
    output logic ack_valid_o,
    output logic [MAX_SEQ-1:0] ack_o,
    output logic tx_win_o,
    output logic rx_win_o,
    output logic radio_on_o
);

    localparam int SW = $clog2(MAX_SEQ);
    localparam int BW = $clog2(MAX_BURST);
    localparam int PW = $clog2(CT_UNIT_CYC + 1);
    localparam int PKT_W = 8 * MAX_PKT_BYTES;
    localparam logic [SW:0] NSEQ = (SW + 1)'(MAX_SEQ);
    localparam logic [BW:0] NBUR = (BW + 1)'(MAX_BURST);
    localparam logic [PW-1:0] PRE_MAX = PW'(CT_UNIT_CYC - 1);
    localparam logic [7:0] IPG_LOAD = 8'(STREAM_IPG_CYC - 3);

    // The window logic relies on these; refuse anything else at elaboration.
    if (MAX_SEQ < 2 * MAX_BURST || MAX_BURST < 2 || MAX_BURST > 8 || SW > 8
            || STREAM_IPG_CYC < 3 || STREAM_IPG_CYC > 255) begin : g_bad_cfg
        $error("wsb_slot_burst: unsupported burst, sequence or gap settings");
    end

    typedef struct packed {
        logic [PW-1:0] pre_cnt;
        logic [15:0] pclk;
        logic slot_ok;
        logic wait_end;
        logic [15:0] s_start;
        logic [15:0] s_end;
        logic s_dir;
        logic s_same;
        logic rx_seen;
        logic [7:0] s_policy;
        wsb_tx_st_t tx_st;
        wsb_mode_t mode;
        logic [7:0] ipg_cnt;
        logic [2:0] pkt_idx;
        logic tx_go;
        logic [SW-1:0] tx_seq;
        logic tx_std;
        logic tx_hs;
        logic [SW-1:0] tx_base;
        logic [MAX_SEQ-1:0] tx_pend;
        logic [SW-1:0] rx_base;
        logic [BW-1:0] rx_slot;
        logic [MAX_BURST-1:0] bval;
        logic [MAX_BURST-1:0][PKT_W-1:0] pbuf;
        logic del_valid;
        logic [SW-1:0] del_seq;
        logic [PKT_W-1:0] del_data;
        logic [MAX_SEQ-1:0] ack;
        logic ack_valid;
        logic en;
        logic [7:0] my_id;
        logic [9:0] rate;
        logic [15:0] guard;
        logic [31:0] rdata;
    } wsb_state_t;

    wsb_state_t q;
    wsb_state_t next_q;

    // Modulo arithmetic on sequence numbers, which need not be a power of two.
    function automatic logic [SW-1:0] seq_add(input logic [SW-1:0] a, input logic [SW:0] b);
        logic [SW:0] s;
        s = {1'b0, a} + b;
        if (s >= NSEQ) begin
            s = s - NSEQ;
        end
        return s[SW-1:0];
    endfunction

    function automatic logic [SW:0] seq_sub(input logic [SW-1:0] a, input logic [SW-1:0] b);
        logic [SW:0] s;
        s = {1'b0, a} + NSEQ - {1'b0, b};
        if (s >= NSEQ) begin
            s = s - NSEQ;
        end
        return s;
    endfunction

    function automatic logic [BW-1:0] slot_add(input logic [BW-1:0] a, input logic [SW:0] d);
        logic [SW+1:0] s;
        s = {2'b00, a} + {1'b0, d};
        if (s >= (SW + 2)'(MAX_BURST)) begin
            s = s - (SW + 2)'(MAX_BURST);
        end
        return s[BW-1:0];
    endfunction

    // Window of MAX_BURST consecutive numbers, so it can never grow wider.
    function automatic logic [MAX_SEQ-1:0] win_mask(input logic [SW-1:0] base);
        logic [MAX_SEQ-1:0] m;
        m = '0;
        for (int i = 0; i < MAX_BURST; i++) begin
            m[seq_add(base, (SW + 1)'(i))] = 1'b1; // RULE26
        end
        return m;
    endfunction

    // First set number at or after base, walking upward with wrap.
    function automatic logic [SW:0] first_set(input logic [SW-1:0] base,
                                              input logic [MAX_SEQ-1:0] m);
        logic [SW:0] r;
        logic [SW-1:0] s;
        r = '0;
        for (int i = MAX_SEQ - 1; i >= 0; i--) begin
            s = seq_add(base, (SW + 1)'(i));
            if (m[s]) begin
                r = {1'b1, s};
            end
        end
        return r;
    endfunction

    function automatic logic is_eol(input wsb_cta_t c);
        return c.ep == EOL_EP && c.dir_in == EOL_DIR && c.setup == EOL_SETUP
            && c.btype == EOL_TYPE && c.dev_id == BCAST_ID; // RULE14
    endfunction

    logic [15:0] slot_len;
    logic [15:0] rx_open;
    logic in_rx_span;
    logic tx_win;
    logic rx_win;
    logic fast;
    logic [SW:0] pick;
    logic [SW:0] ack_pick;
    logic [SW:0] rx_dist;
    logic [BW-1:0] rx_idx;
    logic [MAX_SEQ-1:0] got;

    // Slot windows: wrap-safe differences keep channel-time rollover harmless.
    always_comb begin
        slot_len = q.s_end - q.s_start; // RULE12
        rx_open = q.s_start - q.guard;
        in_rx_span = (q.pclk - rx_open) < (slot_len + q.guard); // RULE8
        tx_win = q.slot_ok && q.s_dir && (q.pclk - q.s_start) < slot_len; // RULE7 RULE10
        rx_win = q.slot_ok && !q.s_dir && (in_rx_span || (q.s_same && q.rx_seen)); // RULE11
        fast = q.rate > RATE_STD_ONLY_MBPS;
        pick = first_set(q.tx_base, q.tx_pend);
        ack_pick = first_set(q.tx_base, ack_in_i);
        rx_dist = seq_sub(rx_seq_i, q.rx_base);
        rx_idx = slot_add(q.rx_slot, rx_dist);
        got = '0;
        for (int i = 0; i < MAX_BURST; i++) begin
            got[seq_add(q.rx_base, (SW + 1)'(i))] = q.bval[slot_add(q.rx_slot, (SW + 1)'(i))];
        end
    end

    // Next-state logic for the whole block.
    always_comb begin
        next_q = q;
        next_q.tx_go = 1'b0;
        next_q.del_valid = 1'b0;
        next_q.ack_valid = 1'b0;
        next_q.rdata = '0;

        // Register port: writes take effect next edge, reads answer one cycle later.
        if (bus_i.we) begin
            if (bus_i.addr == REG_CTRL) begin
                next_q.en = bus_i.wdata[CTRL_EN_BIT];
                next_q.my_id = bus_i.wdata[CTRL_ID_LSB +: 8];
                next_q.rate = bus_i.wdata[CTRL_RATE_LSB +: 10];
            end else if (bus_i.addr == REG_GUARD) begin
                next_q.guard = bus_i.wdata[15:0];
            end
        end
        if (bus_i.re) begin
            if (bus_i.addr == REG_CTRL) begin
                next_q.rdata[CTRL_EN_BIT] = q.en;
                next_q.rdata[CTRL_ID_LSB +: 8] = q.my_id;
                next_q.rdata[CTRL_RATE_LSB +: 10] = q.rate;
            end else if (bus_i.addr == REG_GUARD) begin
                next_q.rdata[15:0] = q.guard;
            end else if (bus_i.addr == REG_STATUS) begin
                next_q.rdata[STAT_OK_BIT] = q.slot_ok;
                next_q.rdata[STAT_DIR_BIT] = q.s_dir;
                next_q.rdata[STAT_TXW_BIT] = tx_win;
                next_q.rdata[STAT_RXW_BIT] = rx_win;
                next_q.rdata[STAT_TXB_LSB +: SW] = q.tx_base;
                next_q.rdata[STAT_RXB_LSB +: SW] = q.rx_base;
            end else if (bus_i.addr == REG_PCLK) begin
                next_q.rdata[15:0] = q.pclk;
            end else if (bus_i.addr == REG_SLOT) begin
                next_q.rdata[15:0] = q.s_start;
                next_q.rdata[SLOT_END_LSB +: 16] = q.s_end;
            end
        end

        // Protocol clock: zeroed at each MMC preamble, free-running otherwise.
        if (mmc_pre_i) begin
            next_q.pclk = '0; // RULE5
            next_q.pre_cnt = '0;
            next_q.slot_ok = 1'b0;
            next_q.wait_end = 1'b0;
            next_q.rx_seen = 1'b0;
            next_q.mode = MODE_NONE;
            next_q.pkt_idx = '0;
        end else if (q.pre_cnt == PRE_MAX) begin
            next_q.pre_cnt = '0;
            next_q.pclk = q.pclk + 16'h0001; // RULE27
        end else begin
            next_q.pre_cnt = q.pre_cnt + PW'(1);
        end
        if (in_rx_span && q.slot_ok) begin
            next_q.rx_seen = 1'b1;
        end

        // Allocation list: only the first own block per MMC is tracked.
        if (cta_valid_i && !mmc_pre_i) begin
            if (q.wait_end) begin
                next_q.s_end = cta_i.start; // RULE12
                next_q.s_same = !is_eol(cta_i) && cta_i.dev_id == q.my_id;
                next_q.wait_end = 1'b0;
                next_q.slot_ok = 1'b1;
            end else if (!is_eol(cta_i) && cta_i.dev_id == q.my_id && !q.slot_ok) begin
                next_q.s_start = cta_i.start; // RULE13
                next_q.s_dir = cta_i.dir_in;
                next_q.s_policy = cta_i.policy;
                next_q.wait_end = 1'b1;
            end
        end

        // Transmit sequencing: grants, preamble choice and the streaming gap.
        case (q.tx_st)
            TX_IDLE: begin
                if (tx_req_i && tx_win && q.en) begin
                    if (tx_hs_i) begin
                        if (q.mode == MODE_NONE) begin
                            next_q.tx_go = 1'b1; // RULE16
                            next_q.tx_hs = 1'b1;
                            next_q.tx_std = 1'b1;
                            next_q.mode = MODE_HS;
                            next_q.tx_st = TX_BUSY;
                        end
                    end else if (q.mode != MODE_HS && pick[SW]) begin
                        next_q.tx_go = 1'b1; // RULE16
                        next_q.tx_hs = 1'b0;
                        next_q.tx_seq = pick[SW-1:0]; // RULE17 RULE22
                        next_q.tx_std = q.pkt_idx == 3'h0 // RULE1
                            || !fast // RULE3
                            || !q.s_policy[q.pkt_idx]; // RULE4
                        next_q.tx_pend[pick[SW-1:0]] = 1'b0;
                        next_q.mode = MODE_DATA;
                        if (q.pkt_idx != 3'h7) begin
                            next_q.pkt_idx = q.pkt_idx + 3'h1;
                        end
                        next_q.tx_st = TX_BUSY;
                    end
                end
            end
            TX_BUSY: begin
                if (tx_done_i) begin
                    next_q.ipg_cnt = IPG_LOAD; // RULE2
                    next_q.tx_st = TX_IPG;
                end
            end
            default: begin
                if (q.ipg_cnt == 8'h00) begin
                    next_q.tx_st = TX_IDLE;
                end else begin
                    next_q.ipg_cnt = q.ipg_cnt - 8'h01;
                end
            end
        endcase

        // Acknowledgement from the far receiver: resend only what it still wants.
        if (ack_in_valid_i && ack_pick[SW]) begin
            next_q.tx_base = ack_pick[SW-1:0]; // RULE19
            next_q.tx_pend = ack_in_i & win_mask(ack_pick[SW-1:0]); // RULE26
        end

        // Receive: store in-window packets, release them in order.
        if (rx_pkt_valid_i && rx_win && q.en && rx_dist < (SW + 1)'(MAX_BURST)) begin
            if (!q.bval[rx_idx]) begin
                next_q.bval[rx_idx] = 1'b1; // RULE25 RULE21
                next_q.pbuf[rx_idx] = rx_data_i;
            end
        end
        if (q.bval[q.rx_slot]) begin
            next_q.del_valid = 1'b1; // RULE18
            next_q.del_seq = q.rx_base;
            next_q.del_data = q.pbuf[q.rx_slot];
            next_q.bval[q.rx_slot] = 1'b0;
            next_q.rx_base = seq_add(q.rx_base, (SW + 1)'(1)); // RULE22
            next_q.rx_slot = slot_add(q.rx_slot, (SW + 1)'(1));
        end
        next_q.ack = win_mask(q.rx_base) & ~got; // RULE23
        if (hs_phase_i) begin
            next_q.ack_valid = 1'b1; // RULE20
        end

        // Configuration event restarts numbering and opens full windows.
        if (cfg_evt_i) begin
            next_q.tx_base = '0; // RULE24
            next_q.rx_base = '0;
            next_q.rx_slot = '0;
            next_q.bval = '0;
            next_q.tx_pend = win_mask('0);
        end

        // Synchronous reset; the transmit window starts full as after a configuration.
        if (!rst_n_i) begin
            next_q = '0;
            next_q.guard = GUARD_RST;
            next_q.tx_pend = win_mask('0);
        end
    end

    always_ff @(posedge core_clk_i) begin
        q <= next_q;
    end

    // Outputs; the radio is powered only while one of the windows is open.
    assign bus_rdata_o = q.rdata;
    assign tx_go_o = q.tx_go;
    assign tx_seq_o = q.tx_seq;
    assign tx_std_pre_o = q.tx_std;
    assign tx_hs_o = q.tx_hs;
    assign del_valid_o = q.del_valid;
    assign del_seq_o = q.del_seq;
    assign del_data_o = q.del_data;
    assign ack_valid_o = q.ack_valid;
    assign ack_o = q.ack;
    assign tx_win_o = tx_win;
    assign rx_win_o = rx_win;
    assign radio_on_o = tx_win | rx_win; // RULE9

    // Cycles since the last packet ended, saturating; read only by the checks.
    logic [8:0] gap;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || tx_done_i) begin
            gap <= 9'h000;
        end else if (gap != 9'h1FF) begin
            gap <= gap + 9'h001;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_pclk_zero: assert property (mmc_pre_i |=> q.pclk == 16'h0000 ##1 q.pclk == 16'h0000) // RULE5
        else $error("protocol clock not zeroed at MMC preamble");
    chk_tx_in_slot: assert property (tx_go_o |-> $past(tx_win)) // RULE10
        else $error("transmit granted outside own IN slot");
    chk_first_std: assert property (tx_go_o && !tx_hs_o && $past(q.pkt_idx) == 3'h0 // RULE1
            |-> tx_std_pre_o)
        else $error("first burst packet without standard preamble");
    chk_slow_std: assert property (tx_go_o && !$past(fast) |-> tx_std_pre_o) // RULE3
        else $error("streaming preamble at low rate");
    chk_ipg_gap: assert property (tx_go_o && $past(q.tx_st, 2) == TX_IPG // RULE2
            |-> gap >= 9'(STREAM_IPG_CYC - 1))
        else $error("inter-packet gap too short");
    chk_no_mix: assert property (tx_go_o |-> $past(q.mode) != (tx_hs_o ? MODE_DATA : MODE_HS)
            && !(tx_hs_o && $past(q.mode) == MODE_HS)) // RULE16
        else $error("data and handshake mixed in one phase");
    chk_del_order: assert property (del_valid_o && !$past(cfg_evt_i) // RULE18
            |-> del_seq_o == $past(q.rx_base) && q.rx_base == seq_add(del_seq_o, (SW + 1)'(1)))
        else $error("delivery out of sequence order");
    chk_win_size: assert property ($countones(q.tx_pend) <= MAX_BURST // RULE26
            && $countones(ack_o) <= MAX_BURST)
        else $error("window wider than maximum burst");
    chk_cfg_reset: assert property (cfg_evt_i |=> q.tx_base == '0 && q.rx_base == '0 // RULE24
            && $countones(q.tx_pend) == MAX_BURST)
        else $error("configuration event did not reset windows");
    chk_ack_phase: assert property (hs_phase_i |=> ack_valid_o) // RULE20
        else $error("no acknowledgement in handshake phase");
    chk_eol_skip: assert property (cta_valid_i && is_eol(cta_i) // RULE13
            |=> !q.wait_end && q.s_start == $past(q.s_start))
        else $error("end-of-list block taken as allocation");
    chk_seq_range: assert property (tx_go_o |-> tx_seq_o < NSEQ) // RULE22
        else $error("sequence number out of range");

    cov_burst: cover property (tx_go_o && !tx_hs_o ##[1:200] tx_go_o && !tx_std_pre_o);
    cov_hs: cover property (tx_go_o && tx_hs_o);
    cov_reorder: cover property (rx_pkt_valid_i && rx_dist == (SW + 1)'(1) && rx_win);
    cov_retry: cover property (ack_in_valid_i && ack_pick[SW] ##[1:200] tx_go_o);

endmodule

`default_nettype wire

// file: testbench/test_wsb_slot_burst.sv
// Self-checking bench: registers, an IN slot with a burst, an OUT slot with reordering.
// Assumes the host model drives the MMC side; the bench plays the application side.
`timescale 1ns/10ps
`default_nettype none
module test_wsb_slot_burst;
    import wsb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wsb_bus_req_t bus = '0;
    logic go = 1'b0, dir = 1'b1, req = 1'b0, done = 1'b0, hs = 1'b0, hs_ph = 1'b0, rxv = 1'b0;
    logic cfg = 1'b0, aiv = 1'b0;
    logic [3:0] rseq = 4'h0;
    logic [31:0] rdat = 32'h0, rd, dd;
    logic mmc, ctv, g, sp, hso, dv, av, txw, rxw, ro;
    wsb_cta_t cta;
    logic [3:0] ts, ds;
    logic [9:0] ack, ain = 10'h000;
    logic [35:0] dq[$];
    int failures = 0;
    int tests_run = 0;
    int n;

    // Free-running 40 MHz core clock.
    initial forever #12.5 clk = ~clk;

    wsb_host_model wsb_host_model_inst (.core_clk_i(clk), .go_i(go), .dir_in_i(dir),
        .mmc_pre_o(mmc), .cta_valid_o(ctv), .cta_o(cta));
    wsb_slot_burst wsb_slot_burst_inst (.core_clk_i(clk), .rst_n_i(rst_n), .bus_i(bus),
        .bus_rdata_o(rd), .mmc_pre_i(mmc), .cta_valid_i(ctv), .cta_i(cta), .cfg_evt_i(cfg),
        .tx_req_i(req), .tx_hs_i(hs), .tx_done_i(done), .tx_go_o(g), .tx_seq_o(ts),
        .tx_std_pre_o(sp), .tx_hs_o(hso), .ack_in_valid_i(aiv), .ack_in_i(ain),
        .rx_pkt_valid_i(rxv), .rx_seq_i(rseq), .rx_data_i(rdat), .del_valid_o(dv),
        .del_seq_o(ds), .del_data_o(dd), .hs_phase_i(hs_ph), .ack_valid_o(av), .ack_o(ack),
        .tx_win_o(txw), .rx_win_o(rxw), .radio_on_o(ro));

    // Deliveries are logged as they happen, since they may land while packets still arrive.
    always @(posedge clk) begin
        if (dv === 1'b1) begin
            dq.push_back({ds, dd});
        end
    end

    // Shared comparison; case inequality so an unknown never passes.
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask

    // Verdict and end of run.
    task automatic summarize();
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Clock edge helpers and register port cycles.
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.we <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        bus.re <= 1'b0;
        #1 chk(rd, e);
    endtask

    // Bounded wait for a grant; n counts the edges waited.
    task automatic wgo();
        n = 0;
        while (g !== 1'b1) begin
            @(posedge clk);
            #1 n++;
            if (n > 400) begin
                chk(40'h0, 40'h1);
                summarize();
            end
        end
    endtask

    // Stimulus pulses: MMC start, packet end, one received packet.
    task automatic mmc_go(input logic d);
        @(posedge clk);
        go <= 1'b1;
        dir <= d;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic fin();
        tick(2);
        done <= 1'b1;
        tick(1);
        done <= 1'b0;
    endtask
    task automatic rx(input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        rxv <= 1'b1;
        rseq <= s;
        rdat <= d;
    endtask

    // Handshake phase answers one cycle later with the receive window bits.
    task automatic s_ack(input logic [9:0] e);
        @(posedge clk);
        hs_ph <= 1'b1;
        @(posedge clk);
        hs_ph <= 1'b0;
        #1 chk({av, ack}, {1'b1, e});
    endtask

    // Reset values, an unmapped read, then enable at 200 Mb/s with own id 5.
    task automatic s_regs();
        rdc(REG_GUARD, 32'h0000_0002);
        rdc(8'h40, 32'h0);
        wr(REG_CTRL, 32'h00C8_0501);
    endtask

    // IN slot: request held early must wait for the slot, then a two-packet burst.
    task automatic s_in();
        mmc_go(1'b1);
        req <= 1'b1;
        tick(60);
        #1 chk({txw, ro}, 2'b00);
        wgo();
        chk({txw, sp, hso, ts}, {3'b110, 4'h0});
        fin();
        wgo();
        chk(n >= STREAM_IPG_CYC - 2, 1'b1);
        chk({sp, ts}, {1'b1, 4'h1});
        req <= 1'b0;
        fin();
        tick(80);
        #1 chk({txw, ro}, 2'b00);
    endtask

    // OUT slot: out-of-order arrival, one packet outside the window.
    task automatic s_out();
        mmc_go(1'b0);
        tick(8);
        rdc(REG_PCLK, 32'h0);
        chk({rxw, ro}, 2'b11);
        rx(4'h1, 32'hA1A1_0001);
        rx(4'h0, 32'hB0B0_0000);
        rx(4'h7, 32'hC7C7_0007);
        @(posedge clk);
        rxv <= 1'b0;
        rdat <= ~rdat;
        tick(10);
        chk(dq.size(), 2);
        chk(dq[0], {4'h0, 32'hB0B0_0000});
        chk(dq[1], {4'h1, 32'hA1A1_0001});
        s_ack(10'h03C);
        tick(200);
        #1 chk({rxw, ro}, 2'b00);
        @(posedge clk);
        cfg <= 1'b1;
        @(posedge clk);
        cfg <= 1'b0;
        s_ack(10'h00F);
    endtask

    // Fast rate, then an ack from 1 on: the next IN burst resends 1, then streams 2.
    task automatic s_retry();
        wr(REG_CTRL, 32'h00C9_0501);
        @(posedge clk);
        {aiv, ain} <= {1'b1, 10'h01E};
        @(posedge clk);
        aiv <= 1'b0;
        mmc_go(1'b1);
        req <= 1'b1;
        wgo();
        chk({sp, hso, ts}, {2'b10, 4'h1});
        fin();
        wgo();
        chk({sp, ts}, {1'b0, 4'h2});
        req <= 1'b0;
        fin();
    endtask

    // A fresh IN slot answered by one handshake packet with a standard preamble.
    task automatic s_hs();
        mmc_go(1'b1);
        {hs, req} <= 2'b11;
        wgo();
        chk({hso, sp}, 2'b11);
        {hs, req} <= 2'b00;
    endtask

    // Main sequence: reset for 16 cycles, then the scenarios.
    initial begin
        tick(16);
        rst_n <= 1'b1;
        s_regs();
        s_in();
        s_ack(10'h00F);
        s_out();
        s_retry();
        s_hs();
        summarize();
    end
endmodule
`default_nettype wire

// file: testbench/wsb_host_model.sv
// Host controller model: one MMC start, then its allocation list in order.
// Assumes the bench pulses go_i for one cycle for each MMC it wants sent.
`timescale 1ns/10ps
`default_nettype none
module wsb_host_model
    import wsb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic go_i,
    input wire logic dir_in_i,
    output logic mmc_pre_o,
    output logic cta_valid_o,
    output wsb_cta_t cta_o
);
    logic [1:0] step;

    // Quiet start so that the block never sees an unknown strobe.
    initial begin
        step = 2'h0;
        mmc_pre_o = 1'b0;
        cta_valid_o = 1'b0;
        cta_o = '0;
    end

    // Own block at tick 2, then the end-of-list block at tick 4 closes it.
    // The end-of-list block carries the reserved field values.
    // Between blocks the bus flips so a stale block is never mistaken for a live one.
    // The next MMC waits for the bench, long after the end-of-list start.
    always @(posedge core_clk_i) begin
        step <= go_i ? 2'h1 : (step == 2'h0 ? 2'h0 : step + 2'h1);
        mmc_pre_o <= go_i;
        cta_valid_o <= step == 2'h1 || step == 2'h2;
        cta_o <= step == 2'h1 ? {4'h1, dir_in_i, 1'b0, 2'h1, 8'h05, 16'h0002, 8'hFF} :
            step == 2'h2 ? {EOL_EP, EOL_DIR, EOL_SETUP, EOL_TYPE, BCAST_ID, 16'h0004, 8'h00} :
            ~cta_o;
    end
endmodule
`default_nettype wire
